// file: acs_adc_seq.sv
`default_nettype none

module acs_adc_seq
    import acs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        external_trigger_pin,
    input  wire logic        comparator_above,
    output var  logic [9:0]  sar_code,
    output var  logic        sample_hold,
    output var  logic [2:0]  channel_sel,
    output var  logic        busy,
    output var  logic        conversion_done_irq
);

    acs_state_t         state_q;
    logic [CNT_W-1:0]   cnt_q;
    logic [3:0]         step_q;
    logic [3:0]         nbits_q;
    logic               first_q;
    logic [3:0]         phase_q;
    logic [9:0]         result_q [4];
    logic [7:0]         hold_q;
    logic               start_q;
    logic               end_flag_q;
    logic               end_armed_q;
    logic               irq_en_q;
    logic               multi_q;
    logic               cks_q;
    logic [2:0]         ch_q;
    logic               trg_hi_q;
    logic               trg_lo_q;
    logic               scan_q;
    logic [IRQ_W-1:0]   irq_status_q;
    logic [IRQ_W-1:0]   irq_mask_q;

    logic               trig_level;
    logic               trig_fall;
    logic               cmp_level;
    logic               trig_start;
    logic               apb_setup;
    logic               apb_done;
    logic               apb_wr;
    logic               apb_rd;
    logic [31:0]        rd_idx;
    logic [31:0]        rd_data;
    logic               rd_hit;
    logic               wr_csr;
    logic [2:0]         grp_first;
    logic               conv_end;
    logic               grp_end;
    logic               seq_clear;
    logic [CNT_W-1:0]   delay_len;
    logic [CNT_W-1:0]   spl_len;
    logic [CNT_W-1:0]   conv_len;

    acs_sync_edge #(.RST_VAL(1'b1)) u_trig_sync
    (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (external_trigger_pin),
        .level    (trig_level),
        .fall     (trig_fall)
    );

    acs_sync_edge #(.RST_VAL(1'b0)) u_cmp_sync
    (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (comparator_above),
        .level    (cmp_level),
        .fall     ()
    );

    // Result register slot hit by an index, bit 1 selects lower byte
    function automatic logic res_hit(input logic [31:0] idx);
        logic [31:0] off;
        off = idx - IDX_RES_A_UPPER;
        res_hit = (off < RES_SPAN) && !off[0];
    endfunction : res_hit

    assign trig_start = trig_fall && trg_hi_q && trg_lo_q;
    assign apb_setup  = psel && !penable;
    assign apb_done   = psel && penable && pready;
    assign apb_wr     = apb_done && pwrite && !pslverr;
    assign apb_rd     = apb_done && !pwrite && !pslverr;
    assign rd_idx     = {2'b00, paddr[31:2]};
    assign wr_csr     = apb_wr && (rd_idx == IDX_CSR);

    // Channel group: multi mode starts at group base
    assign grp_first = multi_q ? {ch_q[2], 2'b00} : ch_q;
    assign conv_end  = (state_q == ST_CONVERT) && (cnt_q == '0) && start_q;
    assign grp_end   = conv_end && (channel_sel == ch_q);
    assign seq_clear = grp_end && !(multi_q && scan_q);

    // Delay follows where the write fell against the prescaler phase
    always_comb
    begin
        if (cks_q)
        begin
            // Idle state after the start flag counts as the first delay state
            delay_len = CNT_W'(TD_MIN_CKS1 - 2) + CNT_W'(phase_q[2:0]);
            spl_len   = CNT_W'(TSPL_CKS1 - 1);
            conv_len  = first_q ? CNT_W'(CONV_FIRST_CKS1 - 1)
                                : CNT_W'(CONV_NEXT_CKS1 - 1);
        end
        else
        begin
            delay_len = CNT_W'(TD_MIN_CKS0 - 2) + CNT_W'(phase_q);
            spl_len   = CNT_W'(TSPL_CKS0 - 1);
            conv_len  = first_q ? CNT_W'(CONV_FIRST_CKS0 - 1)
                                : CNT_W'(CONV_NEXT_CKS0 - 1);
        end
    end

    // Free-running phase stands in for the peripheral clock divider
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            phase_q <= 4'h0;
        else if (phase_q == 4'(PHASE_CNT - 1))
            phase_q <= 4'h0;
        else
            phase_q <= phase_q + 4'h1;
    end

    // Start flag: a set in the same cycle as a clear wins
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            start_q <= 1'b0;
        else if ((wr_csr && pwdata[CSR_START]) || trig_start)
            start_q <= 1'b1;
        else if (wr_csr || seq_clear)
            start_q <= 1'b0;
    end

    // Sequencer
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q     <= ST_IDLE;
            cnt_q       <= '0;
            step_q      <= 4'h0;
            nbits_q     <= 4'h0;
            first_q     <= 1'b1;
            sar_code    <= 10'h000;
            sample_hold <= 1'b0;
            channel_sel <= 3'h0;
            busy        <= 1'b0;
        end
        else if (!start_q && (state_q != ST_IDLE))
        begin
            // Software halt; a new start begins at the group base
            state_q     <= ST_IDLE;
            sample_hold <= 1'b0;
            busy        <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (start_q)
                    begin
                        state_q     <= ST_DELAY;
                        cnt_q       <= delay_len;
                        first_q     <= 1'b1;
                        channel_sel <= grp_first;
                        busy        <= 1'b1;
                    end
                end
                ST_DELAY:
                begin
                    if (cnt_q == '0)
                    begin
                        state_q     <= ST_SAMPLE;
                        cnt_q       <= spl_len;
                        sample_hold <= 1'b1;
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                ST_SAMPLE:
                begin
                    if (cnt_q == '0)
                    begin
                        state_q     <= ST_CONVERT;
                        cnt_q       <= conv_len;
                        sample_hold <= 1'b0;
                        sar_code    <= 10'h200;
                        nbits_q     <= 4'(RES_BITS);
                        step_q      <= 4'h0;
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                ST_CONVERT:
                begin
                    step_q <= step_q + 4'h1;
                    // One trial bit per 16 states; input at full scale keeps all
                    if ((step_q == 4'(BIT_STATES - 1)) && (nbits_q != 4'h0))
                    begin
                        if (!cmp_level)
                            sar_code[nbits_q - 4'h1] <= 1'b0;
                        if (nbits_q > 4'h1)
                            sar_code[nbits_q - 4'h2] <= 1'b1;
                        nbits_q <= nbits_q - 4'h1;
                    end
                    if (cnt_q != '0)
                        cnt_q <= cnt_q - 1'b1;
                    else if (grp_end && !(multi_q && scan_q))
                    begin
                        state_q <= ST_IDLE;
                        busy    <= 1'b0;
                    end
                    else
                    begin
                        // Later conversions skip the start delay
                        state_q     <= ST_SAMPLE;
                        cnt_q       <= CNT_W'(cks_q ? TSPL_CKS1 - 1
                                                    : TSPL_CKS0 - 1);
                        sample_hold <= 1'b1;
                        first_q     <= 1'b0;
                        channel_sel <= grp_end ? grp_first
                                               : channel_sel + 3'h1;
                    end
                end
            endcase
        end
    end

    // Each channel lands in the result slot picked by its low two bits
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
                result_q[i] <= 10'h000;
        end
        else if (conv_end)
            result_q[channel_sel[1:0]] <= sar_code;
    end

    // End flag clears only after a read saw it set
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            end_flag_q  <= 1'b0;
            end_armed_q <= 1'b0;
        end
        else if (grp_end)
        begin
            end_flag_q  <= 1'b1;
            end_armed_q <= end_armed_q;
        end
        else if (wr_csr && !pwdata[CSR_END_FLAG] && end_armed_q)
        begin
            end_flag_q  <= 1'b0;
            end_armed_q <= 1'b0;
        end
        else if (apb_rd && (rd_idx == IDX_CSR) && end_flag_q)
            end_armed_q <= 1'b1;
    end

    // Control fields; start flag has its own process
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_en_q <= 1'b0;
            multi_q  <= 1'b0;
            cks_q    <= 1'b0;
            ch_q     <= 3'h0;
            trg_hi_q <= 1'b0;
            trg_lo_q <= 1'b0;
            scan_q   <= 1'b0;
        end
        else if (wr_csr)
        begin
            irq_en_q <= pwdata[CSR_IRQ_EN];
            multi_q  <= pwdata[CSR_MULTI];
            cks_q    <= pwdata[CSR_CKS];
            ch_q     <= pwdata[CSR_CH_MSB:0];
        end
        else if (apb_wr && (rd_idx == IDX_CR))
        begin
            trg_hi_q <= pwdata[CR_TRG_HI];
            trg_lo_q <= pwdata[CR_TRG_LO];
            scan_q   <= pwdata[CR_SCAN];
        end
    end

    // Sticky events, cleared by reading; a new event wins over the clear
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_status_q <= '0;
            irq_mask_q   <= '0;
        end
        else
        begin
            if (apb_rd && (rd_idx == IDX_IRQ_STATUS))
                irq_status_q <= (irq_status_q & ~prdata[IRQ_W-1:0])
                              | {trig_start, grp_end};
            else
                irq_status_q <= irq_status_q | {trig_start, grp_end};
            if (apb_wr && (rd_idx == IDX_IRQ_MASK))
                irq_mask_q <= pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            conversion_done_irq <= 1'b0;
        else
            conversion_done_irq <= (end_flag_q && irq_en_q)
                                 || |(irq_status_q & irq_mask_q);
    end

    // Upper-byte read parks the low bits for the following lower read
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            hold_q <= 8'h00;
        else if (apb_rd && res_hit(rd_idx) && !rd_idx[1])
            hold_q <= {result_q[rd_idx[3:2]][1:0], 6'h00};
    end

    always_comb
    begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        if (paddr[1:0] != 2'b00)
            rd_hit = 1'b0;
        else if (res_hit(rd_idx))
        begin
            // Lower byte answers from the holding register only
            if (rd_idx[1])
                rd_data[7:0] = hold_q;
            else
                rd_data[7:0] = result_q[rd_idx[3:2]][9:2];
        end
        else if (rd_idx == IDX_CSR)
            rd_data[7:0] = {end_flag_q, irq_en_q, start_q, multi_q,
                            cks_q, ch_q};
        else if (rd_idx == IDX_CR)
            rd_data[7:0] = {trg_hi_q, trg_lo_q, scan_q, 2'b00,
                            CR_RSVD_ONES[2:0]};
        else if (rd_idx == IDX_IRQ_STATUS)
            rd_data[IRQ_W-1:0] = irq_status_q;
        else if (rd_idx == IDX_IRQ_MASK)
            rd_data[IRQ_W-1:0] = irq_mask_q;
        else
            rd_hit = 1'b0;
    end

    // Answer in the first cycle of the access phase; data frozen at setup
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= apb_setup;
            pslverr <= apb_setup && !rd_hit;
            if (apb_setup && !pwrite)
                prdata <= rd_hit ? rd_data : 32'h0000_0000;
        end
    end

endmodule : acs_adc_seq

`default_nettype wire

// file: acs_pkg.sv
// Operation
// - Start, delay, sample, then successive approximation
// - Start delay 17-28 or 10-17 states
// - Conversion time includes delay and sampling
// - First conversion 514-525 or 259-266 states
// - Later group conversions 512 or 256 states
// - Trigger pin honoured only with both enables
// - Trigger falling edge sets start flag
// - Triggered conversion behaves like software start
// - Done interrupt only while enable bit set; an unmasked status bit also raises it
// - Ten-bit unsigned result, full scale all ones
// - Bits 9:2 upper byte, 1:0 at 7:6
// - Single mode: start flag self-clears at end
// - Multi mode: group back to back, then clear
// - Scan mode repeats group until software stops (multi mode only)
// - Upper-byte read loads low byte into holding
`default_nettype none

package acs_pkg;

    // Register indices; byte address is four times the index
    localparam logic [31:0] IDX_RES_A_UPPER = 32'h0040_0080;
    localparam logic [31:0] IDX_RES_A_LOWER = 32'h0040_0082;
    localparam logic [31:0] RES_SPAN        = 32'h0000_0010;
    localparam logic [31:0] IDX_CSR         = 32'h0040_0090;
    localparam logic [31:0] IDX_CR          = 32'h0040_0092;
    localparam logic [31:0] IDX_IRQ_STATUS  = 32'h0040_0094;
    localparam logic [31:0] IDX_IRQ_MASK    = 32'h0040_0096;

    // control_status_register fields
    localparam int CSR_END_FLAG  = 7;
    localparam int CSR_IRQ_EN    = 6;
    localparam int CSR_START     = 5;
    localparam int CSR_MULTI     = 4;
    localparam int CSR_CKS       = 3;
    localparam int CSR_CH_MSB    = 2;
    // control_register fields; bits 2:0 read as one
    localparam int CR_TRG_HI     = 7;
    localparam int CR_TRG_LO     = 6;
    localparam int CR_SCAN       = 5;
    localparam logic [7:0] CR_RSVD_ONES = 8'h07;
    // Interrupt status and mask layout
    localparam int IRQ_DONE      = 0;
    localparam int IRQ_TRIG      = 1;
    localparam int IRQ_W         = 2;

    // Timing in states (one state is one sys_clk cycle)
    localparam int TD_MIN_CKS0    = 'h11;
    localparam int TD_MAX_CKS0    = 'h1C;
    localparam int TD_MIN_CKS1    = 'h0A;
    localparam int TD_MAX_CKS1    = 'h11;
    localparam int TSPL_CKS0      = 'h81;
    localparam int TSPL_CKS1      = 'h41;
    localparam int TCONV_MIN_CKS0 = 'h202;
    localparam int TCONV_MIN_CKS1 = 'h103;
    localparam int TNEXT_CKS0     = 'h200;
    localparam int TNEXT_CKS1     = 'h100;
    localparam int CONV_FIRST_CKS0 = TCONV_MIN_CKS0 - TD_MIN_CKS0 - TSPL_CKS0;
    localparam int CONV_FIRST_CKS1 = TCONV_MIN_CKS1 - TD_MIN_CKS1 - TSPL_CKS1;
    localparam int CONV_NEXT_CKS0  = TNEXT_CKS0 - TSPL_CKS0;
    localparam int CONV_NEXT_CKS1  = TNEXT_CKS1 - TSPL_CKS1;
    localparam int PHASE_CNT      = TD_MAX_CKS0 - TD_MIN_CKS0 + 1;
    localparam int BIT_STATES     = 'h10;
    localparam int RES_BITS       = 'hA;
    localparam int CNT_W          = 9;

    typedef enum logic [1:0]
    {
        ST_IDLE    = 2'b00,
        ST_DELAY   = 2'b01,
        ST_SAMPLE  = 2'b11,
        ST_CONVERT = 2'b10
    } acs_state_t;

endpackage : acs_pkg

`default_nettype wire

// file: acs_sync_edge.sv
`default_nettype none

module acs_sync_edge
#(
    parameter logic RST_VAL = 1'b1
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      level,
    output logic      fall
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
            prev_q <= RST_VAL;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign fall  = prev_q & ~sync_q;

endmodule : acs_sync_edge

`default_nettype wire

// file: acs_adc_seq_checker.sv
`default_nettype none

module acs_checker
    import acs_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pready,
    input  wire logic       pslverr,
    input  wire logic [9:0] sar_code,
    input  wire logic       sample_hold,
    input  wire logic [2:0] channel_sel,
    input  wire logic       busy
);
    timeunit 1ns;
    timeprecision 1ps;

    // Busy rises one state after the start flag, so one state is unseen
    localparam int DLY_LO = TD_MIN_CKS1 - 1;
    localparam int DLY_HI = TD_MAX_CKS0 - 1;

    logic [9:0] spl_q;
    logic [9:0] gap_q;
    logic [9:0] dly_q;
    logic       first_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            spl_q   <= '0;
            gap_q   <= '0;
            dly_q   <= '0;
            first_q <= 1'b1;
        end
        else
        begin
            spl_q   <= sample_hold ? spl_q + 10'h1 : 10'h0;
            gap_q   <= (busy && !sample_hold) ? gap_q + 10'h1 : 10'h0;
            dly_q   <= (busy && !sample_hold && first_q) ? dly_q + 10'h1
                                                         : 10'h0;
            first_q <= !busy ? 1'b1 : (sample_hold ? 1'b0 : first_q);
        end
    end

    sequence seq_setup;
        psel && !penable;
    endsequence

    sequence seq_quiet;
        !sample_hold [*8];
    endsequence

    AST_APB_ANSWER: assert property (seq_setup |=> pready)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_DELAY_QUIET: assert property ($rose(busy) |-> seq_quiet)
        else $error("sampling began without delay");
    AST_HOLD_IN_BUSY: assert property (sample_hold |-> busy)
        else $error("sampling while idle");
    AST_DELAY_RANGE: assert property (
        $rose(sample_hold) && first_q |-> dly_q >= DLY_LO && dly_q <= DLY_HI)
        else $error("start delay out of range");
    AST_SAMPLE_LEN: assert property (
        $fell(sample_hold) && busy |->
            spl_q == TSPL_CKS0 || spl_q == TSPL_CKS1)
        else $error("sampling length wrong");
    AST_NEXT_GAP: assert property (
        $rose(sample_hold) && !first_q |->
            gap_q == CONV_FIRST_CKS0 || gap_q == CONV_FIRST_CKS1 ||
            gap_q == CONV_NEXT_CKS0 || gap_q == CONV_NEXT_CKS1)
        else $error("conversion window length wrong");
    AST_CH_STABLE: assert property (
        sample_hold && $past(sample_hold) |-> $stable(channel_sel))
        else $error("channel moved while sampling");
    AST_IDLE_CODE: assert property (
        !busy && $past(!busy) |-> $stable(sar_code))
        else $error("result changed while idle");
endmodule : acs_checker

bind acs_adc_seq acs_checker acs_checker_i (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .psel        (psel),
    .penable     (penable),
    .pready      (pready),
    .pslverr     (pslverr),
    .sar_code    (sar_code),
    .sample_hold (sample_hold),
    .channel_sel (channel_sel),
    .busy        (busy)
);

`default_nettype wire

// file: acs_comp_model.sv
`default_nettype none

module acs_comp_model
(
    input  wire logic [9:0] sar_code,
    input  wire logic [2:0] channel_sel,
    input  wire logic [9:0] base_level,
    output logic            comparator_above
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] node_level;

    // Each channel sees its own level so slot mix-ups show
    assign node_level = base_level ^ {7'h0, channel_sel};
    assign comparator_above = node_level >= sar_code;
endmodule : acs_comp_model

`default_nettype wire

// file: adc_conversion_sequencer_test.sv
`default_nettype none

module adc_conversion_sequencer_test
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed
    {
        logic [7:0] csr;
        logic [9:0] lvl;
    } acs_row_t;

    logic        sys_clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        external_trigger_pin;
    logic        comparator_above;
    logic [9:0]  sar_code;
    logic        sample_hold;
    logic [2:0]  channel_sel;
    logic        busy;
    logic        conversion_done_irq;
    logic [9:0]  base_level;
    logic [31:0] rd;
    logic        err;
    int          err_count;
    int          compares;
    int          n;
    int          lo;
    int          hi;
    acs_row_t    rows [4];

    acs_adc_seq acs_adc_seq_i (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .external_trigger_pin(external_trigger_pin),
        .comparator_above(comparator_above), .sar_code(sar_code),
        .sample_hold(sample_hold), .channel_sel(channel_sel),
        .busy(busy), .conversion_done_irq(conversion_done_irq)
    );

    acs_comp_model acs_comp_model_i (
        .sar_code(sar_code), .channel_sel(channel_sel),
        .base_level(base_level), .comparator_above(comparator_above)
    );

    task tally_and_finish;
        $display("mismatches %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task chk_range(input int v, input int a, input int b);
        compares++;
        if (v < a || v > b)
        begin
            err_count++;
            $display("BAD %0t count %0d outside %0d..%0d", $time, v, a, b);
        end
    endtask : chk_range

    // Master holds the request until pready is seen at an edge
    task apb(input logic w, input logic [31:0] idx, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx[29:0], 2'b00};
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task run;
        int k;
        n = 0;
        k = 0;
        while (busy !== 1'b1 && k < 40)
        begin
            @(posedge sys_clk);
            k++;
        end
        while (busy === 1'b1 && n < 3000)
        begin
            @(posedge sys_clk);
            n++;
        end
    endtask : run

    task win(input logic clock_rate_select, input int extra);
        lo = (clock_rate_select ? TCONV_MIN_CKS1 : TCONV_MIN_CKS0) + extra;
        hi = lo + (clock_rate_select ? TD_MAX_CKS1 - TD_MIN_CKS1 : TD_MAX_CKS0 - TD_MIN_CKS0);
        // Busy rises one state after the start flag is set
        chk_range(n + 1, lo, hi);
    endtask : win

    task res(input logic [1:0] c, input logic [9:0] v);
        apb(1'b0, IDX_RES_A_UPPER + {c, 2'b00}, 32'h0);
        chk(rd, {24'h0, v[9:2]});
        apb(1'b0, IDX_RES_A_LOWER + {c, 2'b00}, 32'h0);
        chk(rd, {24'h0, v[1:0], 6'h0});
    endtask : res

    task pulse;
        external_trigger_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        external_trigger_pin <= 1'b1;
    endtask : pulse

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (30000) @(posedge sys_clk);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        external_trigger_pin = 1'b1;
        base_level = 10'h0;
        err_count = 0;
        compares = 0;
        rows = '{'{8'h60, 10'h3FF}, '{8'h2B, 10'h155},
                 '{8'h6D, 10'h000}, '{8'h22, 10'h2AA}};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk({busy, conversion_done_irq, pready, sample_hold}, 32'h0);
        foreach (rows[i])
        begin
            base_level <= rows[i].lvl;
            apb(1'b1, IDX_CSR, {24'h0, rows[i].csr});
            run();
            win(rows[i].csr[CSR_CKS], 0);
            apb(1'b0, IDX_CSR, 32'h0);
            chk(rd, {24'h0, 1'b1, rows[i].csr[6:0]} & 32'hDF);
            chk({31'h0, conversion_done_irq}, {31'h0, rows[i].csr[6]});
            res(rows[i].csr[1:0], rows[i].lvl ^ {7'h0, rows[i].csr[2:0]});
            apb(1'b1, IDX_CSR, 32'h0);
            repeat (2) @(posedge sys_clk);
            chk({31'h0, conversion_done_irq}, 32'h0);
        end
        // Rows left the done bit set; clear it so the mask test means something
        apb(1'b0, IDX_IRQ_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, IDX_IRQ_MASK, 32'h1);
        chk({31'h0, conversion_done_irq}, 32'h0);
        apb(1'b1, IDX_CSR, 32'h28);
        run();
        repeat (2) @(posedge sys_clk);
        chk({31'h0, conversion_done_irq}, 32'h1);
        apb(1'b0, IDX_IRQ_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, IDX_CSR, 32'h0);
        apb(1'b1, IDX_CSR, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, conversion_done_irq}, 32'h0);
        apb(1'b1, IDX_IRQ_MASK, 32'h0);
        apb(1'b1, IDX_CR, 32'h40);
        apb(1'b0, IDX_CR, 32'h0);
        chk(rd, {24'h0, 8'h40 | CR_RSVD_ONES});
        pulse();
        repeat (8) @(posedge sys_clk);
        chk({31'h0, busy}, 32'h0);
        apb(1'b1, IDX_CR, 32'hC0);
        base_level <= 10'h0F0;
        apb(1'b1, IDX_CSR, 32'h0B);
        pulse();
        run();
        win(1'b1, 0);
        apb(1'b0, IDX_IRQ_STATUS, 32'h0);
        chk(rd, 32'h3);
        res(2'd3, 10'h0F3);
        apb(1'b0, IDX_CSR, 32'h0);
        apb(1'b1, IDX_CSR, 32'h0);
        apb(1'b1, IDX_CR, 32'h0);
        base_level <= 10'h1C4;
        apb(1'b1, IDX_CSR, 32'h3A);
        run();
        win(1'b1, 2 * TNEXT_CKS1);
        apb(1'b0, IDX_CSR, 32'h0);
        chk(rd, 32'h9A);
        for (int c = 0; c < 3; c++)
            res(c[1:0], 10'h1C4 ^ c[9:0]);
        apb(1'b1, IDX_CSR, 32'h0);
        apb(1'b1, IDX_CR, 32'h20);
        apb(1'b1, IDX_CSR, 32'h38);
        repeat (600) @(posedge sys_clk);
        chk({31'h0, busy}, 32'h1);
        apb(1'b1, IDX_CSR, 32'h18);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, busy}, 32'h0);
        apb(1'b0, IDX_CSR + 32'h8, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= 1'b0;
        paddr   <= {IDX_CSR[29:0], 2'b01};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        chk({31'h0, pslverr}, 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
        tally_and_finish();
    end
endmodule : adc_conversion_sequencer_test

`default_nettype wire
